// [shared/hirs_pkg.sv]
// How it works
// [R1] Output-full set by local data write raises request 10 when its enable is set.
// [R2] Output-full set by local data write raises request 9 when its enable is set.
// [R3] Output-full set by local data write raises request 6 when its enable is set.
// [R4] In direct mode a set enable bit itself asserts its request.
// [R5] Enables clear on written zero, hardware reset and software reset.
// [R6] Outside direct mode, clearing output-full clears all three enables.
// [R7] An enable sets only on a written one after a read showing zero.
// [R8] Enables reset to zero, local read and write, host has no access.
// [R9] Select bit zero gives status; one gives status only with two-way enable.
// [R10] Polarity zero: line released while request clear, driven low while set.
// [R11] Polarity one: line driven low while request clear, released while set.
// [R12] Select register holds seven write-only polarity bits; bits 1 and 0 reset high.
// [R13] Each request level goes out in its own serial interrupt slot.
package hirs_pkg;
  // ==========================================================
  // Register map (word aligned)
  localparam logic [7:0] HIRS_ADR_ENABLE = 8'h00;
  localparam logic [7:0] HIRS_ADR_SELECT = 8'h04;
  localparam logic [7:0] HIRS_ADR_CTRL   = 8'h08;
  localparam logic [7:0] HIRS_ADR_STATUS = 8'h0c;
  localparam logic [7:0] HIRS_ADR_IRQ_ST = 8'h10;
  localparam logic [7:0] HIRS_ADR_IRQ_EN = 8'h14;
  localparam logic [7:0] HIRS_ADR_IRQ_CL = 8'h18;
  // ==========================================================
  // Fields
  localparam int HIRS_BIT_E10 = 2;
  localparam int HIRS_BIT_E9  = 1;
  localparam int HIRS_BIT_E6  = 0;
  localparam int HIRS_BIT_STSEL = 7;
  localparam logic [7:0] HIRS_SELECT_RST = 8'h03;
  localparam int HIRS_CTRL_DIRECT = 0;
  localparam int HIRS_CTRL_TWOWAY = 1;
  localparam int HIRS_CTRL_OBFSET = 2;
  localparam int HIRS_CTRL_OBFCLR = 3;
  localparam int HIRS_CTRL_SWRST  = 4;
  // ==========================================================
  // Serial interrupt frame: start, 13 slots, 3 phases each
  localparam int HIRS_SLOTS = 13;
  localparam logic [6:0] HIRS_NO_SLOT = 7'h7f;
  // Slot numbers of request 11,10,9,6,mgmt(=2 by convention),12,1
  localparam logic [3:0] HIRS_SLOT_11 = 4'hb;
  localparam logic [3:0] HIRS_SLOT_10 = 4'ha;
  localparam logic [3:0] HIRS_SLOT_9  = 4'h9;
  localparam logic [3:0] HIRS_SLOT_6  = 4'h6;
  localparam logic [3:0] HIRS_SLOT_MG = 4'h2;
  localparam logic [3:0] HIRS_SLOT_12 = 4'hc;
  localparam logic [3:0] HIRS_SLOT_1  = 4'h1;
  localparam int HIRS_START_MIN = 4;
  localparam int HIRS_EVENTS = 3;

  typedef enum logic [1:0] {HIRS_IDLE, HIRS_START, HIRS_SLOT} hirs_state_t;
  typedef struct packed {
    logic int11;
    logic int10;
    logic int9;
    logic int6;
    logic mgmt;
    logic int12;
    logic int1;
  } hirs_req_t;
endpackage : hirs_pkg

// [verilog/hirs_host_irq_select.sv]
// The address map and the Wishbone register port were left to the implementer.
module hirs_host_irq_select
  import hirs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        lpc_clk_i,
  input  wire logic        lpc_reset_n_i,
  input  wire logic        serirq_i,
  output logic             serirq_o,
  output logic             serirq_oe_n_o,
  input  wire logic        ext_mgmt_req_i,
  input  wire logic        ext_int11_req_i,
  input  wire logic        ext_int12_req_i,
  input  wire logic        ext_int1_req_i,
  output logic             ch3_status_upper_is_status_o,
  output logic [2:0]       host_request_o,
  output logic             irq_o
);
  // ==========================================================
  // Synchronisers for pins
  logic [1:0] s_lclk, s_lrst, s_sirq, s_mg, s_11, s_12, s_1;
  always_ff @(posedge clk_i) begin
    s_lclk <= {s_lclk[0], lpc_clk_i};
    s_lrst <= {s_lrst[0], lpc_reset_n_i};
    s_sirq <= {s_sirq[0], serirq_i};
    s_mg   <= {s_mg[0], ext_mgmt_req_i};
    s_11   <= {s_11[0], ext_int11_req_i};
    s_12   <= {s_12[0], ext_int12_req_i};
    s_1    <= {s_1[0], ext_int1_req_i};
  end
  logic lclk_d;
  always_ff @(posedge clk_i) begin
    lclk_d <= s_lclk[1];
  end
  wire lclk_rise = s_lclk[1] & ~lclk_d;

  // ==========================================================
  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr      = bus_req & wb_we_i & wb_sel_i[0];
  wire rd      = bus_req & ~wb_we_i;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit

  logic [2:0] enable;
  logic [7:0] select;
  logic       direct_request_mode;
  logic       two_way_reg_enable;
  logic       ch2_output_full_flag;
  logic [2:0] seen_zero;
  logic [HIRS_EVENTS-1:0] irq_st, irq_en;

  wire sw_reset  = wr & hit(wb_adr_i, HIRS_ADR_CTRL) & wb_dat_i[HIRS_CTRL_SWRST];
  wire lpc_reset = ~s_lrst[1];
  wire obf_set   = wr & hit(wb_adr_i, HIRS_ADR_CTRL) & wb_dat_i[HIRS_CTRL_OBFSET];
  wire obf_clr   = wr & hit(wb_adr_i, HIRS_ADR_CTRL) & wb_dat_i[HIRS_CTRL_OBFCLR];
  wire en_wr     = wr & hit(wb_adr_i, HIRS_ADR_ENABLE);

  // ==========================================================
  // Output-full flag and mode bits
  always_ff @(posedge clk_i) begin
    if (rst_i || lpc_reset || sw_reset) begin
      ch2_output_full_flag <= 1'b0;
    end else if (obf_set) begin
      ch2_output_full_flag <= 1'b1;
    end else if (obf_clr) begin
      ch2_output_full_flag <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      direct_request_mode <= 1'b0;
      two_way_reg_enable  <= 1'b0;
    end else if (wr && hit(wb_adr_i, HIRS_ADR_CTRL)) begin
      direct_request_mode <= wb_dat_i[HIRS_CTRL_DIRECT];
      two_way_reg_enable  <= wb_dat_i[HIRS_CTRL_TWOWAY];
    end
  end

  // ==========================================================
  // Enable bits with read-before-set
  always_ff @(posedge clk_i) begin
    if (rst_i || lpc_reset || sw_reset) begin
      seen_zero <= 3'h0;
    end else if (rd && hit(wb_adr_i, HIRS_ADR_ENABLE)) begin
      seen_zero <= ~enable; // [R7]
    end else if (en_wr) begin
      seen_zero <= 3'h0;
    end
  end
  wire obf_fall = ch2_output_full_flag & obf_clr & ~obf_set;
  always_ff @(posedge clk_i) begin
    if (rst_i || lpc_reset || sw_reset) begin
      enable <= 3'h0; // [R5] [R8]
    end else if (!direct_request_mode && obf_fall) begin
      enable <= 3'h0; // [R6]
    end else if (en_wr) begin
      enable <= wb_dat_i[2:0] & (enable | seen_zero); // [R5] [R7]
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || lpc_reset || sw_reset) begin
      select <= HIRS_SELECT_RST; // [R12]
    end else if (wr && hit(wb_adr_i, HIRS_ADR_SELECT)) begin
      select <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // Request levels
  logic [2:0] next_req;
  always_comb begin
    if (direct_request_mode) begin
      next_req = enable; // [R4]
    end else begin
      next_req = enable & {3{ch2_output_full_flag}}; // [R1] [R2] [R3]
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_request_o <= 3'h0;
      ch3_status_upper_is_status_o <= 1'b1;
    end else begin
      host_request_o <= next_req;
      ch3_status_upper_is_status_o <= ~select[HIRS_BIT_STSEL] | two_way_reg_enable; // [R9]
    end
  end
  hirs_req_t req;
  assign req = '{int11: s_11[1], int10: host_request_o[HIRS_BIT_E10],
                 int9: host_request_o[HIRS_BIT_E9], int6: host_request_o[HIRS_BIT_E6],
                 mgmt: s_mg[1], int12: s_12[1], int1: s_1[1]};
  // Line low when request differs from polarity: sel 0 drives low on set
  wire [6:0] drive_low = req ^ select[6:0]; // [R10] [R11]

  // ==========================================================
  // Serial interrupt frame tracker (quiet mode, host starts)
  hirs_state_t state;
  logic [3:0]  slot;
  logic [1:0]  phase;
  logic [3:0]  low_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || lpc_reset) begin
      state <= HIRS_IDLE;
      slot <= 4'h0;
      phase <= 2'h0;
      low_cnt <= 4'h0;
    end else if (lclk_rise) begin
      unique case (state)
        HIRS_IDLE: begin
          if (!s_sirq[1]) begin
            state <= HIRS_START;
            low_cnt <= 4'h1;
          end
        end
        HIRS_START: begin
          if (!s_sirq[1]) begin
            low_cnt <= low_cnt + 4'h1;
          end else if (low_cnt >= 4'(HIRS_START_MIN)) begin
            state <= HIRS_SLOT;
            slot <= 4'h0;
            phase <= 2'h0;
          end else begin
            state <= HIRS_IDLE;
          end
        end
        HIRS_SLOT: begin
          if (phase == 2'h2) begin
            phase <= 2'h0;
            if (slot == 4'(HIRS_SLOTS - 1)) begin
              state <= HIRS_IDLE;
            end else begin
              slot <= slot + 4'h1;
            end
          end else begin
            phase <= phase + 2'h1;
          end
        end
      endcase
    end
  end
  function automatic logic slot_low(input logic [3:0] s, input logic [6:0] d);
    case (s)
      HIRS_SLOT_11: return d[6];
      HIRS_SLOT_10: return d[5];
      HIRS_SLOT_9:  return d[4];
      HIRS_SLOT_6:  return d[3];
      HIRS_SLOT_MG: return d[2];
      HIRS_SLOT_12: return d[1];
      HIRS_SLOT_1:  return d[0];
      default:      return 1'b0;
    endcase
  endfunction : slot_low
  always_ff @(posedge clk_i) begin
    if (rst_i || lpc_reset) begin
      serirq_o <= 1'b1;
      serirq_oe_n_o <= 1'b1;
    end else begin
      serirq_o <= 1'b0;
      serirq_oe_n_o <= ~(state == HIRS_SLOT && phase == 2'h0 && slot_low(slot, drive_low)); // [R13]
    end
  end

  // ==========================================================
  // Local interrupts: output-full set, cleared, frame seen
  logic [HIRS_EVENTS-1:0] ev;
  assign ev = {state == HIRS_START && lclk_rise && s_sirq[1], obf_fall, obf_set};
  wire st_clr = wr & hit(wb_adr_i, HIRS_ADR_IRQ_CL);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st <= '0;
    end else begin
      irq_st <= ev | (irq_st & ~(st_clr ? wb_dat_i[HIRS_EVENTS-1:0] : '0));
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= '0;
      irq_o <= 1'b0;
    end else begin
      if (wr && hit(wb_adr_i, HIRS_ADR_IRQ_EN)) irq_en <= wb_dat_i[HIRS_EVENTS-1:0];
      irq_o <= |(irq_st & irq_en);
    end
  end

  // ==========================================================
  // Bus answer, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (rd) begin
        unique case (wb_adr_i)
          HIRS_ADR_ENABLE: wb_dat_o <= {29'h0, enable}; // [R8]
          HIRS_ADR_CTRL:   wb_dat_o <= {30'h0, two_way_reg_enable, direct_request_mode};
          HIRS_ADR_STATUS: wb_dat_o <= {28'h0, ch3_status_upper_is_status_o,
                                        host_request_o};
          HIRS_ADR_IRQ_ST: wb_dat_o <= {29'h0, irq_st};
          HIRS_ADR_IRQ_EN: wb_dat_o <= {29'h0, irq_en};
          default:         wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Frame length watch: slot clocks counted per frame
  logic [5:0] frame_len;
  always_ff @(posedge clk_i) begin
    if (rst_i || lpc_reset || state != HIRS_SLOT) begin
      frame_len <= 6'h0;
    end else if (lclk_rise) begin
      frame_len <= frame_len + 6'h1;
    end
  end
  wire frame_last = state == HIRS_SLOT && lclk_rise && phase == 2'h2 &&
                    slot == 4'(HIRS_SLOTS - 1);

  // ==========================================================
  // Checks: request levels
  sequence s_obf_write;
    obf_set && !sw_reset && !lpc_reset;
  endsequence
  sequence s_flag_held;
    ch2_output_full_flag && !direct_request_mode;
  endsequence

  AST_DIRECT: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    direct_request_mode |=> host_request_o == $past(enable))
    else $error("direct mode request mismatch");

  AST_OBF_REQ: assert property (@(posedge clk_i) disable iff (rst_i) // [R1] [R2] [R3]
    (!direct_request_mode && ch2_output_full_flag) |=> host_request_o == $past(enable))
    else $error("request not raised");

  AST_OBF_RAISE: assert property (@(posedge clk_i) disable iff (rst_i) // [R1] [R2] [R3]
    s_obf_write ##1 s_flag_held |=> host_request_o == $past(enable))
    else $error("request not raised after data write");

  // ==========================================================
  // Checks: enable bits and reset values
  AST_OBF_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (obf_fall && !direct_request_mode && !en_wr) |=> enable == 3'h0)
    else $error("enables not cleared");

  AST_NOSET: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (en_wr && seen_zero == 3'h0 && !obf_fall) |=> (enable & ~$past(enable)) == 3'h0)
    else $error("enable set without read");

  AST_SW_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    sw_reset |=> enable == 3'h0 && select == HIRS_SELECT_RST && !ch2_output_full_flag)
    else $error("software reset left state");

  AST_LPC_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    lpc_reset |=> enable == 3'h0 && !ch2_output_full_flag)
    else $error("hardware reset left state");

  AST_WRITE_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (en_wr && wb_dat_i[2:0] == 3'h0) |=> enable == 3'h0)
    else $error("written zero did not clear");

  AST_READ_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (rd && hit(wb_adr_i, HIRS_ADR_ENABLE)) |=> wb_dat_o == {29'h0, $past(enable)})
    else $error("enable read data wrong");

  AST_SELECT_INIT: assert property (@(posedge clk_i) // [R12]
    rst_i |=> select == HIRS_SELECT_RST)
    else $error("select reset value wrong");

  // ==========================================================
  // Checks: status select and serial line
  AST_STATUS_SEL: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    1'b1 |=> ch3_status_upper_is_status_o ==
             (!$past(select[HIRS_BIT_STSEL]) || $past(two_way_reg_enable)))
    else $error("status select wrong");

  AST_LINE_SLOT: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    !serirq_oe_n_o |-> $past(state == HIRS_SLOT && phase == 2'h0))
    else $error("line driven outside slot");

  AST_LINE_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i) // [R10] [R11]
    !serirq_oe_n_o |-> $past(slot_low(slot, drive_low)))
    else $error("line driven at wrong polarity");

  AST_FRAME_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    frame_last |-> frame_len == 6'(3 * HIRS_SLOTS - 1))
    else $error("frame length wrong");

  // ==========================================================
  // Checks: bus and local interrupt
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing");

  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> irq_o == $past(|(irq_st & irq_en)))
    else $error("interrupt level wrong");

  AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    (|irq_st && !st_clr) |=> (irq_st & $past(irq_st)) == $past(irq_st))
    else $error("status bit lost");
endmodule : hirs_host_irq_select

// [verification/hirs_lpc_host.sv]
module hirs_lpc_host (
  output logic        lpc_clk_o,
  output logic        drive_low_o,
  input  wire logic   line_i,
  input  wire logic   go_i,
  output logic [12:0] mask_o,
  output logic        done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Host frame: start low, then slots sampled mid-clock
  initial begin
    lpc_clk_o = 0;
    drive_low_o = 0;
    mask_o = '0;
    done_o = 0;
    forever begin
      @(posedge go_i);
      done_o = 0;
      mask_o = '0;
      drive_low_o = 1;
      for (int n = 0; n < 48; n++) begin
        #80 lpc_clk_o = 1;
        if (n == 6) drive_low_o = 0;
        #80 lpc_clk_o = 0;
        if (n >= 6 && n < 45 && !line_i) mask_o[(n-6)/3] = 1;
      end
      done_o = 1;
    end
  end
endmodule : hirs_lpc_host

// [verification/tb_top.sv]
module tb_top;
  import hirs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, lrst_n = 1, go = 0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0, ext = '0;
  logic [31:0] wdat = '0, rdat, exp_q[$];
  logic ack, so, oe_n, st_o, irq, lclk, hlow, done, line;
  logic [2:0] hreq, v;
  logic [6:0] p;
  logic [12:0] mask, m;
  int errors = 0, compares = 0, t;
  assign line = !(hlow | (!oe_n & !so));
  initial forever #2 clk = ~clk;
  hirs_host_irq_select DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .lpc_clk_i(lclk), .lpc_reset_n_i(lrst_n), .serirq_i(line),
    .serirq_o(so), .serirq_oe_n_o(oe_n), .ext_mgmt_req_i(ext[0]),
    .ext_int11_req_i(ext[1]), .ext_int12_req_i(ext[2]), .ext_int1_req_i(ext[3]),
    .ch3_status_upper_is_status_o(st_o), .host_request_o(hreq), .irq_o(irq));
  hirs_lpc_host host (.lpc_clk_o(lclk), .drive_low_o(hlow), .line_i(line), .go_i(go),
    .mask_o(mask), .done_o(done));
  // ==========
  // Checking
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  always @(posedge clk) if (ack === 1'b1 && cyc && !we) chk(rdat, exp_q.pop_front());
  task end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
  // ==========
  // Bus cycles
  task wbc(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    t = 0;
    do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 50);
    if (t >= 50) errors++;
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask : wbc
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wbc(0, a, '0);
  endtask : rd
  task setn(input logic [2:0] b);
    rd(HIRS_ADR_ENABLE, 0);
    wbc(1, HIRS_ADR_ENABLE, {29'h0, b});
  endtask : setn
  // ==========
  // Tests
  initial begin
    v = 3'($urandom(62));
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(HIRS_ADR_ENABLE, 0);
    rd(HIRS_ADR_STATUS, 32'h08);
    rd(HIRS_ADR_SELECT, 0);
    rd(8'h1c, 0);
    wbc(1, HIRS_ADR_ENABLE, 0);
    wbc(1, HIRS_ADR_ENABLE, 7);
    rd(HIRS_ADR_ENABLE, 0);
    setn(7);
    rd(HIRS_ADR_STATUS, 32'h08);
    wbc(1, HIRS_ADR_ENABLE, 0);
    rd(HIRS_ADR_ENABLE, 0);
    for (int b = 0; b < 3; b++) begin
      setn(3'(1 << b));
      wbc(1, HIRS_ADR_CTRL, 32'h4);
      rd(HIRS_ADR_STATUS, 32'h08 | (1 << b));
      chk(hreq, 1 << b);
      wbc(1, HIRS_ADR_CTRL, 32'h8);
      rd(HIRS_ADR_ENABLE, 0);
    end
    wbc(1, HIRS_ADR_CTRL, 32'h1);
    v = 3'($urandom);
    setn(v);
    wbc(1, HIRS_ADR_CTRL, 32'h9);
    rd(HIRS_ADR_STATUS, {28'h0, 1'b1, v});
    rd(HIRS_ADR_ENABLE, {29'h0, v});
    wbc(1, HIRS_ADR_IRQ_EN, 32'h4);
    p = 7'h03;
    for (int f = 0; f < 2; f++) begin
      ext <= 4'($urandom);
      if (f == 1) begin
        p = 7'($urandom);
        wbc(1, HIRS_ADR_SELECT, {25'h0, p});
      end
      go <= 1;
      @(posedge clk);
      go <= 0;
      t = 0;
      while (!done && t < 5000) begin @(posedge clk); t++; end
      if (t >= 5000) errors++;
      m = '0;
      m[11] = ext[1] ^ p[6];
      m[10] = v[2] ^ p[5];
      m[9] = v[1] ^ p[4];
      m[6] = v[0] ^ p[3];
      m[2] = ext[0] ^ p[2];
      m[12] = ext[2] ^ p[1];
      m[1] = ext[3] ^ p[0];
      chk(mask, m);
      chk(so, 0);
      chk(irq, 1);
      wbc(1, HIRS_ADR_IRQ_CL, 32'h4);
      @(posedge clk);
      chk(irq, 0);
    end
    wbc(1, HIRS_ADR_CTRL, 32'h10);
    rd(HIRS_ADR_ENABLE, 0);
    setn(7);
    lrst_n <= 0;
    repeat (4) @(posedge clk);
    lrst_n <= 1;
    rd(HIRS_ADR_ENABLE, 0);
    for (int k = 0; k < 4; k++) begin
      wbc(1, HIRS_ADR_SELECT, {24'h0, k[0], 7'h0});
      wbc(1, HIRS_ADR_CTRL, {30'h0, k[1], 1'b0});
      rd(HIRS_ADR_STATUS, {28'h0, !k[0] | k[1], 3'h0});
    end
    end_of_test;
  end
endmodule : tb_top
